// >>> rtl/dcmc_pkg.sv
/*
  package for the two-comparator mode control block: register map, field
  positions, reset values, mode encodings, carrier structs.
  assumes a single 40 MHz core clock domain.
*/
package dcmc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [1:0] DCMC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] DCMC_ADDR_STAT = 2'h1;
  localparam logic [1:0] DCMC_ADDR_MASK = 2'h2;
  localparam logic [1:0] DCMC_ADDR_DIR = 2'h3;
  localparam logic [7:0] DCMC_CTRL_RST = 8'h00;
  localparam logic [7:0] DCMC_MASK_RST = 8'h00;
  localparam logic [4:0] DCMC_DIR_RST = 5'h1F;
  localparam int DCMC_BIT_SECOND = 7;
  localparam int DCMC_BIT_FIRST = 6;
  localparam int DCMC_BIT_SWITCH = 3;
  localparam int DCMC_BIT_CHG = 0;
  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DCMC_MODE_RESET = 3'h0,
    DCMC_MODE_ONE_IND = 3'h1,
    DCMC_MODE_VREF = 3'h2,
    DCMC_MODE_COMMON = 3'h3,
    DCMC_MODE_TWO_IND = 3'h4,
    DCMC_MODE_ONE_ONLY = 3'h5,
    DCMC_MODE_OUT = 3'h6,
    DCMC_MODE_OFF = 3'h7
  } dcmc_mode_t;
  // routing selects for one comparator input
  typedef enum logic [2:0] {
    DCMC_SRC_NONE = 3'h0,
    DCMC_SRC_PIN0 = 3'h1,
    DCMC_SRC_PIN1 = 3'h2,
    DCMC_SRC_PIN2 = 3'h3,
    DCMC_SRC_PIN3 = 3'h4,
    DCMC_SRC_VREF = 3'h5
  } dcmc_src_t;
  typedef struct packed {
    dcmc_src_t first_pos;
    dcmc_src_t first_neg;
    dcmc_src_t second_pos;
    dcmc_src_t second_neg;
    logic first_on;
    logic second_on;
  } dcmc_route_t;
  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } dcmc_pins_t;
endpackage

// >>> rtl/dcmc_top.sv
/*
  two-comparator mode control: control register, routing decode,
  result sync, change flag with mask and interrupt, port-A pin mux.
  assumes analog comparators and pins sit outside; register port is a
  plain strobe bus with read data one cycle after the read strobe.
*/
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module dcmc_top
  import dcmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // comparator analog side
  input wire logic first_raw,
  input wire logic second_raw,
  output dcmc_route_t route,
  // port-A pins
  input wire logic [4:0] port_a_latch,
  input wire logic [4:0] port_a_in,
  output dcmc_pins_t port_a_pins,
  output logic [4:0] port_a_read,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] ctrl_ff, nxt_ctrl;
  logic [4:0] dir_ff, nxt_dir;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [1:0] latched_ff, nxt_latched;
  logic [2:0] s1_sync_ff, s2_sync_ff;
  logic [1:0] res_ff, nxt_res;
  dcmc_mode_t mode;
  logic sw;
  logic mismatch;
  logic hit_ctrl;

  assign mode = dcmc_mode_t'(ctrl_ff[2:0]);
  assign sw = ctrl_ff[DCMC_BIT_SWITCH];
  assign hit_ctrl = (reg_wr | reg_rd) && (reg_addr == DCMC_ADDR_CTRL);

  // ----------------------------------------------------------------
  // result synchroniser: three stages, change counts when two agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_sync_ff <= 3'h0;
      s2_sync_ff <= 3'h0;
      res_ff <= 2'h0;
    end else begin
      s1_sync_ff <= {s1_sync_ff[1:0], first_raw};
      s2_sync_ff <= {s2_sync_ff[1:0], second_raw};
      res_ff <= nxt_res;
    end
  end

  always_comb begin
    nxt_res = res_ff;
    // result follows the comparator: high when plus above minus
    if (s1_sync_ff[1] == s1_sync_ff[2]) begin
      nxt_res[0] = s1_sync_ff[2];
    end
    if (s2_sync_ff[1] == s2_sync_ff[2]) begin
      nxt_res[1] = s2_sync_ff[2];
    end
    // a comparator that is off holds its result low
    if (!route.first_on) begin
      nxt_res[0] = 1'b0;
    end
    if (!route.second_on) begin
      nxt_res[1] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // input routing decode
  // ----------------------------------------------------------------
  always_comb begin
    route = '{DCMC_SRC_NONE, DCMC_SRC_NONE, DCMC_SRC_NONE, DCMC_SRC_NONE,
              1'b1, 1'b1};
    case (mode)
      DCMC_MODE_RESET: begin
        route.first_on = 1'b0;
        route.second_on = 1'b0;
      end
      DCMC_MODE_ONE_IND, DCMC_MODE_COMMON: begin
        route.first_neg = sw ? DCMC_SRC_PIN3 : DCMC_SRC_PIN0;
        route.first_pos = DCMC_SRC_PIN2;
        route.second_neg = DCMC_SRC_PIN1;
        route.second_pos = DCMC_SRC_PIN2;
      end
      DCMC_MODE_VREF: begin
        route.first_neg = sw ? DCMC_SRC_PIN3 : DCMC_SRC_PIN0;
        route.second_neg = sw ? DCMC_SRC_PIN2 : DCMC_SRC_PIN1;
        route.first_pos = DCMC_SRC_VREF;
        route.second_pos = DCMC_SRC_VREF;
      end
      DCMC_MODE_TWO_IND, DCMC_MODE_OUT: begin
        route.first_neg = DCMC_SRC_PIN0;
        route.first_pos = DCMC_SRC_PIN3;
        route.second_neg = DCMC_SRC_PIN1;
        route.second_pos = DCMC_SRC_PIN2;
      end
      DCMC_MODE_ONE_ONLY: begin
        route.first_on = 1'b0;
        route.second_neg = DCMC_SRC_PIN1;
        route.second_pos = DCMC_SRC_PIN2;
      end
      DCMC_MODE_OFF: begin
        route.first_on = 1'b0;
        route.second_on = 1'b0;
      end
      default: begin
        route.first_on = 1'b0;
        route.second_on = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pins: analog map, output mux, read-back
  // ----------------------------------------------------------------
  logic [4:0] analog;
  always_comb begin
    case (mode)
      DCMC_MODE_RESET, DCMC_MODE_ONE_IND, DCMC_MODE_VREF, DCMC_MODE_TWO_IND: begin
        analog = 5'h0F;
      end
      DCMC_MODE_COMMON, DCMC_MODE_OUT: analog = 5'h07;
      DCMC_MODE_ONE_ONLY: analog = 5'h06;
      default: analog = 5'h00;
    endcase
  end

  always_comb begin
    port_a_pins.out = port_a_latch;
    // raw outputs skip the synchroniser on purpose: pin timing follows
    // the analog edge, so glitches near threshold reach the pin
    if (mode == DCMC_MODE_OUT) begin
      port_a_pins.out[3] = first_raw;
      port_a_pins.out[4] = second_raw;
    end
    port_a_pins.oe = ~dir_ff;
  end

  assign port_a_read = port_a_in & ~analog;

  // ----------------------------------------------------------------
  // registers, change flag, read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_dir = dir_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_latched = latched_ff;
    nxt_rdata = 8'h00;
    mismatch = (res_ff != latched_ff);
    if (reg_wr) begin
      case (reg_addr)
        DCMC_ADDR_CTRL: nxt_ctrl = reg_wdata[3:0];
        DCMC_ADDR_STAT: nxt_stat = stat_ff & ~reg_wdata;
        DCMC_ADDR_MASK: nxt_mask = reg_wdata;
        DCMC_ADDR_DIR: nxt_dir = reg_wdata[4:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        DCMC_ADDR_CTRL: nxt_rdata = {res_ff[1], res_ff[0], 2'h0, ctrl_ff};
        DCMC_ADDR_STAT: nxt_rdata = stat_ff;
        DCMC_ADDR_MASK: nxt_rdata = mask_ff;
        DCMC_ADDR_DIR: nxt_rdata = {3'h0, dir_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
    if (hit_ctrl) begin
      nxt_latched = res_ff;
    end
    // set wins over a clear in the same cycle
    if (mismatch) begin
      nxt_stat[DCMC_BIT_CHG] = 1'b1;
    end
    nxt_stat[7:1] = 7'h00;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= DCMC_CTRL_RST[3:0];
      dir_ff <= DCMC_DIR_RST;
      mask_ff <= DCMC_MASK_RST;
      stat_ff <= 8'h00;
      latched_ff <= 2'h0;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      dir_ff <= nxt_dir;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
      latched_ff <= nxt_latched;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  // irq is not gated during mode change; software masks it
  assign irq = |(stat_ff & mask_ff);
endmodule
`default_nettype wire

// >>> testbench/dcmc_analog_model.sv
/* comparator pair model for the far side.
   assumes digital levels stand in for analog ones. */
`timescale 1ns/10ps
`default_nettype none
module dcmc_analog_model
  import dcmc_pkg::*;
(
  // routing from the block
  input wire dcmc_route_t route,
  // levels
  input wire logic [3:0] pin_lvl,
  input wire logic vref,
  // results
  output logic first_raw,
  output logic second_raw
);
  // index matches source enum; unselected reads low
  logic [5:0] v;
  assign v = {vref, pin_lvl, 1'b0};
  assign first_raw = route.first_on & v[route.first_pos] & ~v[route.first_neg];
  assign second_raw = route.second_on & v[route.second_pos] & ~v[route.second_neg];
endmodule
`default_nettype wire

// >>> testbench/dcmc_sva.sv
/* checker for the control block.
   assumes binding to dcmc_top ports. */
`timescale 1ns/10ps
`default_nettype none
module dcmc_sva
  import dcmc_pkg::*;
(
  // top ports
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic first_raw,
  input wire logic second_raw,
  input wire dcmc_route_t route,
  input wire logic [4:0] port_a_latch,
  input wire logic [4:0] port_a_in,
  input wire dcmc_pins_t port_a_pins,
  input wire logic [4:0] port_a_read,
  input wire logic irq
);
  // shadow of the mode field
  logic [2:0] mode_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mode_ff <= 3'h0;
    else if (reg_wr && reg_addr == DCMC_ADDR_CTRL) mode_ff <= reg_wdata[2:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_mode_read_back: assert property ($past(reg_rd && reg_addr == DCMC_ADDR_CTRL)
    |-> reg_rdata[2:0] == $past(mode_ff)) else $error("mode read back");
  a_unused_bits_zero: assert property ($past(reg_rd && reg_addr == DCMC_ADDR_CTRL)
    |-> reg_rdata[5:4] == 2'h0) else $error("bits 5:4 set");
  a_dir_gates_oe: assert property ($past(reg_wr && reg_addr == DCMC_ADDR_DIR)
    |-> port_a_pins.oe == ~$past(reg_wdata[4:0])) else $error("oe");
  a_out_mode_pins: assert property (mode_ff == 3'h6
    |-> port_a_pins.out[4:3] == {second_raw, first_raw}) else $error("pins 3,4");
  a_latch_pass: assert property (mode_ff != 3'h6
    |-> port_a_pins.out == port_a_latch) else $error("latch path");
  a_vref_plus: assert property (mode_ff == 3'h2
    |-> route.first_pos == DCMC_SRC_VREF && route.second_pos == DCMC_SRC_VREF)
    else $error("vref route");
  a_off_mode: assert property (mode_ff == 3'h7 |-> !route.first_on && !route.second_on)
    else $error("not off");
  a_analog_zero: assert property (mode_ff == 3'h0 |-> port_a_read == {port_a_in[4], 4'h0})
    else $error("port read");
  c_out_mode: cover property (mode_ff == 3'h6);
  c_irq: cover property (irq);
  c_stat_read: cover property (reg_rd && reg_addr == DCMC_ADDR_STAT);
endmodule
bind dcmc_top dcmc_sva u_dcmc_sva (.*);
`default_nettype wire

// >>> testbench/test_dual_comparator_mode_control.sv
/* self-checking bench for the control block.
   assumes the analog model beside it. */
`timescale 1ns/10ps
`default_nettype none
module test_dual_comparator_mode_control
  import dcmc_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, vref = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] pin_lvl = 4'h0;
  logic [4:0] port_a_latch = 5'h00, port_a_in = 5'h00, port_a_read;
  logic first_raw, second_raw, irq;
  dcmc_route_t route;
  dcmc_pins_t port_a_pins;
  int fails = 0, check_count = 0, cyc = 0;
  dcmc_top u_dcmc_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_raw(first_raw),
    .second_raw(second_raw), .route(route), .port_a_latch(port_a_latch),
    .port_a_in(port_a_in), .port_a_pins(port_a_pins), .port_a_read(port_a_read), .irq(irq));
  dcmc_analog_model u_dcmc_analog_model (.route(route), .pin_lvl(pin_lvl), .vref(vref),
    .first_raw(first_raw), .second_raw(second_raw));
  always #12.5 clk = ~clk;
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hung handshake cannot stall the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    rd(DCMC_ADDR_CTRL, 8'h00);
    rd(DCMC_ADDR_DIR, 8'h1F);
    chk({3'h0, port_a_pins.oe}, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      wr(DCMC_ADDR_CTRL, {5'h1E, 3'(m)});
      rd(DCMC_ADDR_CTRL, {5'h00, 3'(m)});
    end
    wr(DCMC_ADDR_CTRL, 8'h09);
    rd(DCMC_ADDR_CTRL, 8'h09);
    $display("mode test done");
  endtask
  task automatic t_results;
    wr(DCMC_ADDR_CTRL, 8'h02);
    @(posedge clk) vref <= 1'b1;
    settle(8);
    rd(DCMC_ADDR_CTRL, 8'hC2);
    @(posedge clk) {vref, pin_lvl} <= 5'h0F;
    settle(8);
    rd(DCMC_ADDR_CTRL, 8'h02);
    $display("result test done");
  endtask
  task automatic t_irq;
    rd(DCMC_ADDR_CTRL, 8'h02);
    wr(DCMC_ADDR_STAT, 8'h01);
    rd(DCMC_ADDR_STAT, 8'h00);
    wr(DCMC_ADDR_MASK, 8'h01);
    @(posedge clk) {vref, pin_lvl} <= 5'h10;
    settle(8);
    chk({7'h0, irq}, 8'h01);
    rd(DCMC_ADDR_STAT, 8'h01);
    wr(DCMC_ADDR_MASK, 8'h00);
    settle(1);
    chk({7'h0, irq}, 8'h00);
    rd(DCMC_ADDR_CTRL, 8'hC2);
    wr(DCMC_ADDR_STAT, 8'h01);
    rd(DCMC_ADDR_STAT, 8'h00);
    $display("interrupt test done");
  endtask
  task automatic t_pins;
    wr(DCMC_ADDR_CTRL, 8'h06);
    wr(DCMC_ADDR_DIR, 8'h00);
    @(posedge clk) {port_a_latch, port_a_in} <= {5'h12, 5'h1D};
    pin_lvl <= 4'h8;
    settle(2);
    chk({3'h0, port_a_pins.oe}, 8'h1F);
    chk({6'h0, port_a_pins.out[4:3]}, 8'h01);
    chk({3'h0, port_a_read}, 8'h18);
    wr(DCMC_ADDR_CTRL, 8'h00);
    settle(1);
    chk({3'h0, port_a_pins.out}, 8'h12);
    chk({3'h0, port_a_read}, 8'h10);
    $display("pin test done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_modes();
    t_results();
    t_irq();
    t_pins();
    conclude();
  end
endmodule
`default_nettype wire
